//--- hw/csd_strap_decoder.sv
// Strap capture at reset release, setting decode and runtime GPIO setup
`timescale 1ns/1ps
// Contract
// R1 - Sample all straps once both resets are released.
// R2 - Hold reset state while external reset low; release starts capture.
// R3 - Weak pull-down mode class selects SMBus master for I2C bridging.
// R4 - Weak pull-up mode class selects SMBus slave for configuration.
// R5 - Mode strap has six classes; the four mid and strong ones are reserved.
// R6 - Latch positive and negative line disable straps per port, 1 disables.
// R7 - A port is disabled only when both its line straps are high.
// R8 - Disabling a port's USB 2.0 side also disables its USB 3 side.
// R9 - Fixed-port strap: none, 3, 3-4, 3-5, 3-6, sixth reserved.
// R10 - Charge strap: none, 1, 1-2, 1-3, 1-4, 1-6.
// R11 - Each GPIO is input with optional pull or output driving low/high.
// R12 - GPIO setup changes at runtime through internal register writes.
// R13 - Latched straps ignore pin activity until the next reset release.
module csd_strap_decoder #(
   parameter int NGPIO = 8,
   parameter int GAW   = 3
) (
   input  wire logic                   CLK,
   input  wire logic                   ARST_N,
   input  wire logic                   POR_N,
   input  wire logic [2:0]             MODE_CLASS,
   input  wire logic [5:0]             POS_LINE_PORT_OFF_STRAP,
   input  wire logic [5:0]             NEG_LINE_PORT_OFF_STRAP,
   input  wire logic [2:0]             FIXED_PORT_COUNT_STRAP,
   input  wire logic [2:0]             CHARGE_PORT_COUNT_STRAP,
   input  wire logic                   GPIO_WR,
   input  wire logic [GAW-1:0]         GPIO_WR_ADDR,
   input  wire csd_pkg::csd_gpio_cfg_s GPIO_WR_DATA,
   input  wire logic [GAW-1:0]         GPIO_RD_ADDR,
   output csd_pkg::csd_gpio_cfg_s      GPIO_RD_DATA,
   input  wire logic [NGPIO-1:0]       GPIO_PIN_IN,
   output logic      [NGPIO-1:0]       GPIO_PIN_OUT,
   output logic      [NGPIO-1:0]       GPIO_PIN_OE_N,
   output logic      [NGPIO-1:0]       GPIO_PULL_DOWN,
   output logic      [NGPIO-1:0]       GPIO_PULL_UP,
   output logic      [NGPIO-1:0]       GPIO_IN_LEVEL,
   output logic                        STRAPS_VALID,
   output csd_pkg::csd_role_e          SMBUS_ROLE,
   output logic                        MODE_RESERVED,
   output logic      [5:0]             USB2_PORT_OFF,
   output logic      [5:0]             USB3_PORT_OFF,
   output logic      [5:0]             FIXED_PORTS,
   output logic                        FIXED_RESERVED,
   output logic      [5:0]             CHARGE_PORTS
);
   // Both reset sources hold the block; capture follows release
   wire rst_n = ARST_N & POR_N;  // see R2

   typedef enum logic [1:0] {
      ST_CAPTURE = 2'b01,
      ST_HOLD    = 2'b10
   } csd_state_e;

   csd_state_e          state;
   csd_state_e          next_state;
   csd_pkg::csd_straps_s strap;
   csd_pkg::csd_straps_s next_strap;
   csd_pkg::csd_straps_s pin_sample;

   assign pin_sample = '{mode:       MODE_CLASS,
                         pos_line:   POS_LINE_PORT_OFF_STRAP,
                         neg_line:   NEG_LINE_PORT_OFF_STRAP,
                         fixed_cnt:  FIXED_PORT_COUNT_STRAP,
                         charge_cnt: CHARGE_PORT_COUNT_STRAP};

   // First clock after release samples the pins, then holds
   wire capture = (state == ST_CAPTURE);                    // see R1
   assign next_strap = capture ? pin_sample : strap;        // see R13
   always_comb
   begin
      next_state = ST_HOLD;
      unique case (state)
         ST_CAPTURE: next_state = ST_HOLD;                       // see R1
         ST_HOLD:    next_state = ST_HOLD;                       // see R13
         default:    next_state = ST_HOLD;
      endcase
   end

   always_ff @(posedge CLK or negedge rst_n)
   begin
      if (!rst_n)
         state <= ST_CAPTURE;
      else
         state <= next_state;
   end

   always_ff @(posedge CLK or negedge rst_n)
   begin
      if (!rst_n)
         strap <= '{mode: csd_pkg::RST_CLASS, pos_line: csd_pkg::RST_PORTS,
                    neg_line: csd_pkg::RST_PORTS, fixed_cnt: csd_pkg::RST_CLASS,
                    charge_cnt: csd_pkg::RST_CLASS};
      else
         strap <= next_strap;                               // see R1
   end

   // Mode decode
   csd_pkg::csd_role_e next_role;
   logic               next_mode_rsv;
   always_comb
   begin
      next_role     = csd_pkg::ROLE_NONE;
      next_mode_rsv = 1'b0;
      unique case (strap.mode)
         csd_pkg::CLS_WEAK_PD: next_role = csd_pkg::ROLE_MASTER;  // see R3
         csd_pkg::CLS_WEAK_PU: next_role = csd_pkg::ROLE_SLAVE;   // see R4
         csd_pkg::CLS_MID_PD, csd_pkg::CLS_MID_PU,
         csd_pkg::CLS_STRONG_PD, csd_pkg::CLS_STRONG_PU:
            next_mode_rsv = 1'b1;                                 // see R5
         default: next_mode_rsv = 1'b1;
      endcase
   end

   // Port disable: both lines high
   wire [5:0] next_port_off = strap.pos_line & strap.neg_line;    // see R6 see R7

   // Fixed-port and charge-port decode
   logic [5:0] next_fixed;
   logic       next_fixed_rsv;
   logic [5:0] next_charge;
   always_comb
   begin
      next_fixed     = csd_pkg::FIXED_NONE;
      next_fixed_rsv = 1'b0;
      unique case (strap.fixed_cnt)                               // see R9
         csd_pkg::CLS_WEAK_PD:   next_fixed = csd_pkg::FIXED_NONE;
         csd_pkg::CLS_WEAK_PU:   next_fixed = csd_pkg::FIXED_P3;
         csd_pkg::CLS_MID_PD:    next_fixed = csd_pkg::FIXED_P34;
         csd_pkg::CLS_MID_PU:    next_fixed = csd_pkg::FIXED_P35;
         csd_pkg::CLS_STRONG_PD: next_fixed = csd_pkg::FIXED_P36;
         default:                next_fixed_rsv = 1'b1;
      endcase
   end

   always_comb
   begin
      next_charge = csd_pkg::CHG_NONE;
      unique case (strap.charge_cnt)                              // see R10
         csd_pkg::CLS_WEAK_PD:   next_charge = csd_pkg::CHG_NONE;
         csd_pkg::CLS_WEAK_PU:   next_charge = csd_pkg::CHG_P1;
         csd_pkg::CLS_MID_PD:    next_charge = csd_pkg::CHG_P12;
         csd_pkg::CLS_MID_PU:    next_charge = csd_pkg::CHG_P13;
         csd_pkg::CLS_STRONG_PD: next_charge = csd_pkg::CHG_P14;
         csd_pkg::CLS_STRONG_PU: next_charge = csd_pkg::CHG_P16;
         default:                next_charge = csd_pkg::CHG_NONE;
      endcase
   end

   // Settings load only past the capture edge, so no stale role shows early
   wire settle = !capture;                                        // see R2

   always_ff @(posedge CLK or negedge rst_n)
   begin
      if (!rst_n)
         STRAPS_VALID <= 1'b0;
      else
         STRAPS_VALID <= settle;                                  // see R1
   end

   // Interface role and reserved-mode flag
   always_ff @(posedge CLK or negedge rst_n)
   begin
      if (!rst_n)
         SMBUS_ROLE <= csd_pkg::ROLE_NONE;
      else if (settle)
         SMBUS_ROLE <= next_role;
   end

   always_ff @(posedge CLK or negedge rst_n)
   begin
      if (!rst_n)
         MODE_RESERVED <= 1'b0;
      else if (settle)
         MODE_RESERVED <= next_mode_rsv;
   end

   // Port disable masks, both speeds
   always_ff @(posedge CLK or negedge rst_n)
   begin
      if (!rst_n)
         USB2_PORT_OFF <= csd_pkg::RST_PORTS;
      else if (settle)
         USB2_PORT_OFF <= next_port_off;
   end

   always_ff @(posedge CLK or negedge rst_n)
   begin
      if (!rst_n)
         USB3_PORT_OFF <= csd_pkg::RST_PORTS;
      else if (settle)
         USB3_PORT_OFF <= next_port_off;                          // see R8
   end

   // Fixed-port and charge-port masks
   always_ff @(posedge CLK or negedge rst_n)
   begin
      if (!rst_n)
         FIXED_PORTS <= csd_pkg::RST_PORTS;
      else if (settle)
         FIXED_PORTS <= next_fixed;
   end

   always_ff @(posedge CLK or negedge rst_n)
   begin
      if (!rst_n)
         FIXED_RESERVED <= 1'b0;
      else if (settle)
         FIXED_RESERVED <= next_fixed_rsv;
   end

   always_ff @(posedge CLK or negedge rst_n)
   begin
      if (!rst_n)
         CHARGE_PORTS <= csd_pkg::RST_PORTS;
      else if (settle)
         CHARGE_PORTS <= next_charge;
   end

   // Runtime GPIO setup store
   csd_pkg::csd_gpio_cfg_s gcfg [NGPIO];

   csd_gpio_cfg_mem #(
      .NGPIO (NGPIO),
      .AW    (GAW)
   ) u_gpio_mem (
      .clk     (CLK),
      .arst_n  (rst_n),
      .wr_en   (GPIO_WR),                                         // see R12
      .wr_addr (GPIO_WR_ADDR),
      .wr_data (GPIO_WR_DATA),
      .rd_addr (GPIO_RD_ADDR),
      .rd_data (GPIO_RD_DATA),
      .cfg     (gcfg)
   );

   genvar g;
   generate
      for (g = 0; g < NGPIO; g++)
      begin : g_pin
         wire drive = gcfg[g].is_output;                          // see R11
         wire pdn   = !drive && gcfg[g].pull_en && !gcfg[g].pull_up;
         wire pup   = !drive && gcfg[g].pull_en && gcfg[g].pull_up;
         // Drive level and enable
         always_ff @(posedge CLK or negedge rst_n)
         begin
            if (!rst_n)
               GPIO_PIN_OUT[g] <= 1'b0;
            else
               GPIO_PIN_OUT[g] <= gcfg[g].out_level;
         end

         always_ff @(posedge CLK or negedge rst_n)
         begin
            if (!rst_n)
               GPIO_PIN_OE_N[g] <= 1'b1;
            else
               GPIO_PIN_OE_N[g] <= !drive;
         end

         // Pulls apply to inputs only
         always_ff @(posedge CLK or negedge rst_n)
         begin
            if (!rst_n)
               GPIO_PULL_DOWN[g] <= 1'b0;
            else
               GPIO_PULL_DOWN[g] <= pdn;
         end

         always_ff @(posedge CLK or negedge rst_n)
         begin
            if (!rst_n)
               GPIO_PULL_UP[g] <= 1'b0;
            else
               GPIO_PULL_UP[g] <= pup;
         end

         // Input level sample
         always_ff @(posedge CLK or negedge rst_n)
         begin
            if (!rst_n)
               GPIO_IN_LEVEL[g] <= 1'b0;
            else
               GPIO_IN_LEVEL[g] <= GPIO_PIN_IN[g];
         end
      end
   endgenerate
endmodule // csd_strap_decoder

//--- hw/csd_pkg.sv
// Package: strap classes, port counts and setting structs for the strap decoder
package csd_pkg;
   localparam int NPORT = 6;
   localparam int CLS_W = 3;

   // Six resistor classes as decoded by the analog front end
   typedef enum logic [2:0] {
      CLS_WEAK_PD   = 3'h0,
      CLS_WEAK_PU   = 3'h1,
      CLS_MID_PD    = 3'h2,
      CLS_MID_PU    = 3'h3,
      CLS_STRONG_PD = 3'h4,
      CLS_STRONG_PU = 3'h5
   } csd_class_e;

   // SMBus interface role chosen by the mode-select strap
   typedef enum logic [1:0] {
      ROLE_NONE   = 2'h0,
      ROLE_MASTER = 2'h1,
      ROLE_SLAVE  = 2'h2
   } csd_role_e;

   // Reset values of latched straps
   localparam logic [2:0] RST_CLASS = 3'h0;
   localparam logic [5:0] RST_PORTS = 6'h00;

   // Port masks per class (bit 0 is port 1)
   localparam logic [5:0] FIXED_NONE = 6'h00;
   localparam logic [5:0] FIXED_P3   = 6'h04;
   localparam logic [5:0] FIXED_P34  = 6'h0c;
   localparam logic [5:0] FIXED_P35  = 6'h1c;
   localparam logic [5:0] FIXED_P36  = 6'h3c;
   localparam logic [5:0] CHG_NONE   = 6'h00;
   localparam logic [5:0] CHG_P1     = 6'h01;
   localparam logic [5:0] CHG_P12    = 6'h03;
   localparam logic [5:0] CHG_P13    = 6'h07;
   localparam logic [5:0] CHG_P14    = 6'h0f;
   localparam logic [5:0] CHG_P16    = 6'h3f;

   // Raw strap sample
   typedef struct packed {
      logic [2:0] mode;
      logic [5:0] pos_line;
      logic [5:0] neg_line;
      logic [2:0] fixed_cnt;
      logic [2:0] charge_cnt;
   } csd_straps_s;

   // One GPIO pin setup
   typedef struct packed {
      logic is_output;
      logic out_level;
      logic pull_en;
      logic pull_up;
   } csd_gpio_cfg_s;
endpackage

//--- hw/csd_gpio_cfg_mem.sv
// GPIO configuration store: per-pin setup words, written at runtime
`timescale 1ns/1ps
module csd_gpio_cfg_mem #(
   parameter int NGPIO = 8,
   parameter int AW    = 3
) (
   input  wire logic                   clk,
   input  wire logic                   arst_n,
   input  wire logic                   wr_en,
   input  wire logic [AW-1:0]          wr_addr,
   input  wire csd_pkg::csd_gpio_cfg_s wr_data,
   input  wire logic [AW-1:0]          rd_addr,
   output csd_pkg::csd_gpio_cfg_s      rd_data,
   output csd_pkg::csd_gpio_cfg_s      cfg [NGPIO]
);
   csd_pkg::csd_gpio_cfg_s mem [NGPIO];

   genvar g;
   generate
      for (g = 0; g < NGPIO; g++)
      begin : g_ent
         wire hit = wr_en && (wr_addr == AW'(g));
         always_ff @(posedge clk or negedge arst_n)
         begin
            if (!arst_n)
               mem[g] <= '0;
            else if (hit)
               mem[g] <= wr_data;
         end
         assign cfg[g] = mem[g];
      end
   endgenerate

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         rd_data <= '0;
      else
         rd_data <= mem[rd_addr];
   end
endmodule // csd_gpio_cfg_mem

//--- tb/csd_strap_decoder_checker.sv
// Checker: strap decode and GPIO setup timing at the decoder ports
`timescale 1ns/1ps
module csd_strap_decoder_checker #(
   parameter int NGPIO = 8,
   parameter int GAW   = 3
) (
   input wire logic                   CLK,
   input wire logic                   ARST_N,
   input wire logic                   POR_N,
   input wire logic [2:0]             MODE_CLASS,
   input wire logic [5:0]             POS_LINE_PORT_OFF_STRAP,
   input wire logic [5:0]             NEG_LINE_PORT_OFF_STRAP,
   input wire logic                   GPIO_WR,
   input wire logic [GAW-1:0]         GPIO_WR_ADDR,
   input wire csd_pkg::csd_gpio_cfg_s GPIO_WR_DATA,
   input wire logic [NGPIO-1:0]       GPIO_PIN_OE_N,
   input wire logic [NGPIO-1:0]       GPIO_PULL_DOWN,
   input wire logic [NGPIO-1:0]       GPIO_PULL_UP,
   input wire logic                   STRAPS_VALID,
   input wire csd_pkg::csd_role_e     SMBUS_ROLE,
   input wire logic                   MODE_RESERVED,
   input wire logic [5:0]             USB2_PORT_OFF,
   input wire logic [5:0]             USB3_PORT_OFF,
   input wire logic [5:0]             FIXED_PORTS
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!ARST_N || !POR_N);

   valid_rise_a: assert property (
      !STRAPS_VALID ##1 !STRAPS_VALID |=> STRAPS_VALID) else $error("straps valid late");
   role_idle_a: assert property (
      !STRAPS_VALID |-> SMBUS_ROLE == csd_pkg::ROLE_NONE) else $error("role set before valid");
   valid_hold_a: assert property (
      STRAPS_VALID |=> STRAPS_VALID) else $error("straps valid dropped");
   usb3_follow_a: assert property (
      USB3_PORT_OFF == USB2_PORT_OFF) else $error("usb3 off differs from usb2 off");
   port_off_a: assert property (
      $rose(STRAPS_VALID) |-> USB2_PORT_OFF ==
      ($past(POS_LINE_PORT_OFF_STRAP, 2) & $past(NEG_LINE_PORT_OFF_STRAP, 2)))
      else $error("port off mask wrong");
   role_decode_a: assert property (
      $rose(STRAPS_VALID) |-> MODE_RESERVED == ($past(MODE_CLASS, 2) >= 3'h2) &&
      SMBUS_ROLE == ($past(MODE_CLASS, 2) == 3'h0 ? csd_pkg::ROLE_MASTER :
      $past(MODE_CLASS, 2) == 3'h1 ? csd_pkg::ROLE_SLAVE : csd_pkg::ROLE_NONE))
      else $error("mode decode wrong");
   straps_frozen_a: assert property (
      STRAPS_VALID |=> $stable(SMBUS_ROLE) && $stable(USB2_PORT_OFF) && $stable(FIXED_PORTS))
      else $error("latched settings moved");
   gpio_oe_a: assert property (
      GPIO_WR |-> ##2 GPIO_PIN_OE_N[$past(GPIO_WR_ADDR, 2)] == !$past(GPIO_WR_DATA.is_output, 2))
      else $error("gpio drive enable wrong");
   pull_input_a: assert property (
      ((GPIO_PULL_UP | GPIO_PULL_DOWN) & ~GPIO_PIN_OE_N) == '0 &&
      (GPIO_PULL_UP & GPIO_PULL_DOWN) == '0) else $error("pull on driven pin");
endmodule // csd_strap_decoder_checker

bind csd_strap_decoder csd_strap_decoder_checker #(.NGPIO(NGPIO), .GAW(GAW)) u_chk (
   .CLK, .ARST_N, .POR_N, .MODE_CLASS, .POS_LINE_PORT_OFF_STRAP, .NEG_LINE_PORT_OFF_STRAP,
   .GPIO_WR, .GPIO_WR_ADDR, .GPIO_WR_DATA, .GPIO_PIN_OE_N, .GPIO_PULL_DOWN, .GPIO_PULL_UP,
   .STRAPS_VALID, .SMBUS_ROLE, .MODE_RESERVED, .USB2_PORT_OFF, .USB3_PORT_OFF, .FIXED_PORTS);

//--- tb/csd_board_model.sv
// Board model: strap resistors and both reset sources
`timescale 1ns/1ps
module csd_board_model (
   input  wire logic                  clk,
   input  wire logic                  por_req,
   input  wire logic                  ext_req,
   input  wire csd_pkg::csd_straps_s  cfg,
   output logic                       por_n,
   output logic                       arst_n,
   output csd_pkg::csd_straps_s       pins
);
   int hold = 0;
   assign por_n  = !por_req;
   assign arst_n = !ext_req;
   always @(posedge clk)
      hold <= (por_req || ext_req) ? 0 : hold + 1;
   // Straps stay put briefly past release, then the pins carry other traffic
   assign pins = (hold < 4) ? cfg : ~cfg ^ csd_pkg::csd_straps_s'(21'(hold));
endmodule // csd_board_model

//--- tb/csd_strap_decoder_tb.sv
// Testbench: strap capture cases and runtime GPIO setup
`timescale 1ns/1ps
module csd_strap_decoder_tb;
   logic                   clk = 1'b0;
   logic                   por_req = 1'b1;
   logic                   ext_req = 1'b1;
   logic                   por_n, arst_n, gpio_wr = 1'b0;
   csd_pkg::csd_straps_s   cfg = '0;
   csd_pkg::csd_straps_s   pins;
   logic [2:0]             wr_addr = 3'h0;
   logic [2:0]             rd_addr = 3'h0;
   csd_pkg::csd_gpio_cfg_s wr_data = '0;
   csd_pkg::csd_gpio_cfg_s rd_data;
   logic [7:0]             pin_in = 8'h00;
   logic [7:0]             pin_out, oe_n, pull_dn, pull_up, in_level;
   logic                   valid, mode_rsv, fix_rsv;
   csd_pkg::csd_role_e     role;
   logic [5:0]             usb2_off, usb3_off, fixed, charge;
   int                     num_errors = 0;
   int                     n_checks = 0;
   localparam logic [5:0] FX [5] = '{csd_pkg::FIXED_NONE, csd_pkg::FIXED_P3,
      csd_pkg::FIXED_P34, csd_pkg::FIXED_P35, csd_pkg::FIXED_P36};
   localparam logic [5:0] CH [8] = '{csd_pkg::CHG_NONE, csd_pkg::CHG_P1, csd_pkg::CHG_P12,
      csd_pkg::CHG_P13, csd_pkg::CHG_P14, csd_pkg::CHG_P16, csd_pkg::CHG_NONE, csd_pkg::CHG_NONE};
   // Output low, output high, input pull-down, input pull-up
   localparam logic [3:0] GC [4] = '{4'h8, 4'hc, 4'h2, 4'h3};

   always #2.5 clk = ~clk;

   csd_board_model board (.clk(clk), .por_req(por_req), .ext_req(ext_req), .cfg(cfg),
      .por_n(por_n), .arst_n(arst_n), .pins(pins));

   csd_strap_decoder #(.NGPIO(8), .GAW(3)) DUT (
      .CLK(clk), .ARST_N(arst_n), .POR_N(por_n), .MODE_CLASS(pins.mode),
      .POS_LINE_PORT_OFF_STRAP(pins.pos_line), .NEG_LINE_PORT_OFF_STRAP(pins.neg_line),
      .FIXED_PORT_COUNT_STRAP(pins.fixed_cnt), .CHARGE_PORT_COUNT_STRAP(pins.charge_cnt),
      .GPIO_WR(gpio_wr), .GPIO_WR_ADDR(wr_addr), .GPIO_WR_DATA(wr_data),
      .GPIO_RD_ADDR(rd_addr), .GPIO_RD_DATA(rd_data), .GPIO_PIN_IN(pin_in),
      .GPIO_PIN_OUT(pin_out), .GPIO_PIN_OE_N(oe_n), .GPIO_PULL_DOWN(pull_dn),
      .GPIO_PULL_UP(pull_up), .GPIO_IN_LEVEL(in_level), .STRAPS_VALID(valid),
      .SMBUS_ROLE(role), .MODE_RESERVED(mode_rsv), .USB2_PORT_OFF(usb2_off),
      .USB3_PORT_OFF(usb3_off), .FIXED_PORTS(fixed), .FIXED_RESERVED(fix_rsv),
      .CHARGE_PORTS(charge));

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic print_verdict();
      $display("checks %0d, mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic check_decode(input int i, input logic [5:0] off);
      chk(8'(valid), 8'h01);
      chk(8'(role), 8'(i == 0 ? csd_pkg::ROLE_MASTER :
         i == 1 ? csd_pkg::ROLE_SLAVE : csd_pkg::ROLE_NONE));
      chk(8'(mode_rsv), 8'(i >= 2));
      chk(8'(usb2_off), 8'(off));
      chk(8'(usb3_off), 8'(off));
      chk(8'(fix_rsv), 8'(i >= 5));
      if (i < 5) chk(8'(fixed), 8'(FX[i]));
      chk(8'(charge), 8'(CH[i]));
   endtask

   // Odd cases reset from power-on, even ones from the external pin
   task automatic strap_case(input int i);
      logic [5:0] p, q;
      p = 6'h15 ^ 6'(i);
      q = 6'h33 ^ 6'(i * 5);
      cfg = '{3'(i), p, q, 3'(i), 3'(i)};
      if (i % 2 == 1) por_req = 1'b1;
      else ext_req = 1'b1;
      tick(2);
      chk(8'(valid), 8'h00);
      chk(oe_n, 8'hff);
      chk(8'(role), 8'h00);
      por_req = 1'b0;
      ext_req = 1'b0;
      tick(1);
      chk(8'(valid), 8'h00);
      chk(8'(role), 8'h00);
      tick(1);
      check_decode(i, p & q);
      tick(6);
      check_decode(i, p & q);
      $display("strap case %0d done", i);
   endtask

   initial
   begin
      tick(12);
      for (int i = 0; i < 4; i++) strap_case(i);
      gpio_wr = 1'b1;
      for (int k = 0; k < 8; k++)
      begin
         wr_addr = 3'(k);
         wr_data = GC[k % 4];
         tick(1);
      end
      gpio_wr = 1'b0;
      pin_in = 8'h5a;
      tick(2);
      chk(pin_out, 8'h22);
      chk(oe_n, 8'hcc);
      chk(pull_dn, 8'h44);
      chk(pull_up, 8'h88);
      chk(in_level, 8'h5a);
      for (int k = 0; k < 8; k++)
      begin
         rd_addr = 3'(k);
         tick(1);
         chk(8'(rd_data), 8'(GC[k % 4]));
      end
      $display("gpio test done");
      for (int i = 4; i < 8; i++) strap_case(i);
      print_verdict();
   end

   initial
   begin
      repeat (2000) @(posedge clk);
      num_errors++;
      print_verdict();
   end
endmodule // csd_strap_decoder_tb
